/* design/rstc_pkg.sv */
// Purpose: Constants for the register-space transfer core
// Assumes: One clock, synchronous active-low reset
// Notes:   Core-internal register locations are fixed below

package rstc_pkg;

  // ==========================================================
  // Register space geometry
  localparam int unsigned NUM_MODULES   = 16;
  localparam int unsigned REGS_PER_MOD  = 32;
  localparam int unsigned MOD_W         = 4;
  localparam int unsigned IDX_W         = 5;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned ADDR_W        = 16;

  typedef logic [MOD_W-1:0]  rstc_mod_t;
  typedef logic [IDX_W-1:0]  rstc_idx_t;
  typedef logic [DATA_W-1:0] rstc_data_t;
  typedef logic [ADDR_W-1:0] rstc_addr_t;

  // ==========================================================
  // Module groups
  localparam rstc_mod_t PERIPH_LAST_MOD = 4'h5;

  // ==========================================================
  // Core-internal registers
  localparam rstc_mod_t PFX_MOD = 4'hB;
  localparam rstc_mod_t IP_MOD  = 4'hC;
  localparam rstc_idx_t IP_IDX  = 5'h00;

  // ==========================================================
  // Reset values
  localparam rstc_addr_t IP_RESET  = 16'h8000;
  localparam logic [7:0] PFX_RESET = 8'h00;

endpackage : rstc_pkg

/* design/rstc_core.sv */
// Purpose: Fetch, decode and width-converting transfer engine
// Assumes: Program memory returns the word one cycle after its address
// Notes:   Three stages: fetch, decode/source request, execute/write

`timescale 1ns/1ps

module rstc_core (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // Program memory fetch port
  output logic [rstc_pkg::ADDR_W-1:0] prog_addr,
  input  wire logic [rstc_pkg::DATA_W-1:0] instr_data,
  // Branch and interrupt unit
  input  wire logic                br_load,
  input  wire logic [rstc_pkg::ADDR_W-1:0] br_target,
  // Source read request and answer
  output logic                     src_rd,
  output logic [rstc_pkg::MOD_W-1:0]  src_mod,
  output logic [rstc_pkg::IDX_W-1:0]  src_idx,
  input  wire logic [rstc_pkg::DATA_W-1:0] src_data,
  input  wire logic                src_defined,
  input  wire logic                src_is16,
  input  wire logic                src_mod_has8,
  // Destination query and answer
  output logic [rstc_pkg::MOD_W-1:0]  dst_mod,
  output logic [rstc_pkg::IDX_W-1:0]  dst_idx,
  input  wire logic                dst_defined,
  input  wire logic                dst_is16,
  // Destination write strobe
  output logic                     wr_en,
  output logic [rstc_pkg::MOD_W-1:0]  wr_mod,
  output logic [rstc_pkg::IDX_W-1:0]  wr_idx,
  output logic [rstc_pkg::DATA_W-1:0] wr_data
);
  import rstc_pkg::*;

  // ==========================================================
  // State
  rstc_addr_t ip_reg,      ip_next;
  logic       if_valid_reg, if_valid_next;
  rstc_addr_t if_pc_reg,   if_pc_next;
  logic       ex_valid_reg, ex_valid_next;
  rstc_addr_t ex_pc_reg,   ex_pc_next;
  logic       ex_regsrc_reg, ex_regsrc_next;
  logic [7:0] ex_imm_reg,  ex_imm_next;
  logic       ex_pfx_reg,  ex_pfx_next;
  logic       ex_ipw_reg,  ex_ipw_next;
  logic       src_rd_reg,  src_rd_next;
  rstc_mod_t  src_mod_reg, src_mod_next;
  rstc_idx_t  src_idx_reg, src_idx_next;
  rstc_mod_t  dst_mod_reg, dst_mod_next;
  rstc_idx_t  dst_idx_reg, dst_idx_next;
  logic [7:0] prefix_reg,  prefix_next;
  logic       wr_en_reg,   wr_en_next;
  rstc_mod_t  wr_mod_reg,  wr_mod_next;
  rstc_idx_t  wr_idx_reg,  wr_idx_next;
  rstc_data_t wr_data_reg, wr_data_next;

  // ==========================================================
  // Decode
  wire        dec_regsrc  = instr_data[15];
  wire [2:0]  dec_dsub    = instr_data[14:12];
  wire [3:0]  dec_dmod    = instr_data[11:8];
  wire [3:0]  dec_sidx    = instr_data[7:4];
  wire [3:0]  dec_smod    = instr_data[3:0];

  // Prefix in execute supplies extra index bits to the next word
  wire        pfx_fwd     = ex_valid_reg & ex_pfx_reg;
  wire [1:0]  dst_ext     = pfx_fwd ? dst_idx_reg[1:0] : 2'b00;
  wire        src_ext     = pfx_fwd & dst_idx_reg[2];
  // Destination indexes 0-7 and source indexes 0-15 need no prefix; higher ones take the extension bits
  wire [4:0]  dec_didx    = {dst_ext, dec_dsub};
  wire [4:0]  dec_sidx_x  = {src_ext, dec_sidx};
  // Peripheral and system modules share one decode path
  wire        dec_pfx     = (dec_dmod == PFX_MOD) && (dec_didx[4:3] == 2'b00);
  wire        dec_ipw     = (dec_dmod == IP_MOD) && (dec_didx == IP_IDX);

  // ==========================================================
  // Execute: source selection
  wire        src_ip      = ex_regsrc_reg && (src_mod_reg == IP_MOD) && (src_idx_reg == IP_IDX);
  wire [15:0] ip_seen     = ex_pc_reg + 16'h0001;
  wire [15:0] undef_val   = src_mod_has8 ? {prefix_reg, 8'h00} : 16'h0000;
  wire [15:0] src_val     = !ex_regsrc_reg ? {8'h00, ex_imm_reg} :
                            src_ip         ? ip_seen :
                            src_defined    ? src_data : undef_val;
  wire        src8        = !ex_regsrc_reg | (!src_ip & src_defined & !src_is16);

  // ==========================================================
  // Execute: width conversion
  wire        dst_int     = ex_pfx_reg | ex_ipw_reg;
  wire        dst16       = ex_ipw_reg | (!ex_pfx_reg & dst_is16);
  wire [15:0] cnv_narrow  = {8'h00, src_val[7:0]};
  wire [15:0] cnv_widen   = {prefix_reg, src_val[7:0]};
  wire [15:0] cnv_val     = !dst16 ? cnv_narrow :
                            src8   ? cnv_widen : src_val;

  // ==========================================================
  // Execute: effects
  wire        wr_fire     = ex_valid_reg & !dst_int & dst_defined;
  wire        pfx_load    = ex_valid_reg & ex_pfx_reg;
  wire        ipw_fire    = ex_valid_reg & ex_ipw_reg;
  wire        redirect    = ipw_fire | br_load;
  wire [15:0] ip_target   = ipw_fire ? cnv_val : br_target;
  wire [15:0] ip_incr     = ip_reg + 16'h0001;

  // ==========================================================
  // Next-state
  always_comb begin
    ip_next        = redirect ? ip_target : ip_incr;
    if_valid_next  = !redirect;
    if_pc_next     = ip_reg;
    ex_valid_next  = if_valid_reg & !redirect;
    ex_pc_next     = if_pc_reg;
    ex_regsrc_next = dec_regsrc;
    ex_imm_next    = instr_data[7:0];
    ex_pfx_next    = dec_pfx;
    ex_ipw_next    = dec_ipw;
    src_rd_next    = if_valid_reg & !redirect & dec_regsrc;
    src_mod_next   = dec_smod;
    src_idx_next   = dec_sidx_x;
    dst_mod_next   = dec_dmod;
    dst_idx_next   = dec_didx;
    prefix_next    = pfx_load ? cnv_val[7:0] : PFX_RESET;
    wr_en_next     = wr_fire;
    wr_mod_next    = dst_mod_reg;
    wr_idx_next    = dst_idx_reg;
    wr_data_next   = cnv_val;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ip_reg        <= IP_RESET;
      if_valid_reg  <= 1'b0;
      if_pc_reg     <= 16'h0000;
      ex_valid_reg  <= 1'b0;
      ex_pc_reg     <= 16'h0000;
      ex_regsrc_reg <= 1'b0;
      ex_imm_reg    <= 8'h00;
      ex_pfx_reg    <= 1'b0;
      ex_ipw_reg    <= 1'b0;
      src_rd_reg    <= 1'b0;
      src_mod_reg   <= 4'h0;
      src_idx_reg   <= 5'h00;
      dst_mod_reg   <= 4'h0;
      dst_idx_reg   <= 5'h00;
      prefix_reg    <= PFX_RESET;
      wr_en_reg     <= 1'b0;
      wr_mod_reg    <= 4'h0;
      wr_idx_reg    <= 5'h00;
      wr_data_reg   <= 16'h0000;
    end else begin
      ip_reg        <= ip_next;
      if_valid_reg  <= if_valid_next;
      if_pc_reg     <= if_pc_next;
      ex_valid_reg  <= ex_valid_next;
      ex_pc_reg     <= ex_pc_next;
      ex_regsrc_reg <= ex_regsrc_next;
      ex_imm_reg    <= ex_imm_next;
      ex_pfx_reg    <= ex_pfx_next;
      ex_ipw_reg    <= ex_ipw_next;
      src_rd_reg    <= src_rd_next;
      src_mod_reg   <= src_mod_next;
      src_idx_reg   <= src_idx_next;
      dst_mod_reg   <= dst_mod_next;
      dst_idx_reg   <= dst_idx_next;
      prefix_reg    <= prefix_next;
      wr_en_reg     <= wr_en_next;
      wr_mod_reg    <= wr_mod_next;
      wr_idx_reg    <= wr_idx_next;
      wr_data_reg   <= wr_data_next;
    end
  end

  // ==========================================================
  // Outputs; fetch port is read-only by construction
  assign prog_addr = ip_reg;
  assign src_rd    = src_rd_reg;
  assign src_mod   = src_mod_reg;
  assign src_idx   = src_idx_reg;
  assign dst_mod   = dst_mod_reg;
  assign dst_idx   = dst_idx_reg;
  assign wr_en     = wr_en_reg;
  assign wr_mod    = wr_mod_reg;
  assign wr_idx    = wr_idx_reg;
  assign wr_data   = wr_data_reg;

  // ==========================================================
  // Checks
  chk_ip_reset_value: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> ip_reg == IP_RESET)
    else $error("instruction pointer not at reset address");

  chk_ip_auto_incr: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !redirect |=> ip_reg == $past(ip_incr))
    else $error("instruction pointer did not increment");

  chk_ip_sw_write: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ipw_fire |=> ip_reg == $past(cnv_val) ##1 if_pc_reg == $past(cnv_val, 2))
    else $error("fetch not redirected to written address");

  chk_redirect_flush: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (br_load && !ipw_fire) |=> (ip_reg == $past(br_target)) && !ex_valid_reg && !if_valid_reg)
    else $error("branch did not load pointer and flush");

  chk_prefix_clear: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    pfx_load ##1 !pfx_load |=> prefix_reg == 8'h00)
    else $error("prefix did not clear after one cycle");

  chk_undef_dst_nowr: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ex_valid_reg && !dst_defined) |=> !wr_en_reg)
    else $error("write issued to undefined destination");

  chk_narrow_dst_data: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_fire && !dst_is16) |=> wr_en_reg && wr_data_reg == {8'h00, $past(src_val[7:0])})
    else $error("narrow destination data wrong");

  chk_widen_prefix: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_fire && dst_is16 && src8) |=> wr_data_reg == {$past(prefix_reg), $past(src_val[7:0])})
    else $error("widening move high byte not prefix");

  chk_same16_copy: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_fire && dst_is16 && ex_regsrc_reg && !src_ip && src_defined && src_is16) |=> wr_data_reg == $past(src_data))
    else $error("16-bit move not copied unchanged");

  chk_undef_src_val: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_fire && dst_is16 && ex_regsrc_reg && !src_ip && !src_defined) |=>
      wr_data_reg == ($past(src_mod_has8) ? {$past(prefix_reg), 8'h00} : 16'h0000))
    else $error("undefined source value wrong");

  chk_undef16_zero: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_fire && dst_is16 && ex_regsrc_reg && !src_ip && !src_defined && !src_mod_has8) |=> wr_data_reg == 16'h0000)
    else $error("undefined source in wide module not zero");

  chk_dummy_src_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ex_valid_reg && ex_regsrc_reg && !dst_defined) |-> src_rd_reg)
    else $error("source read dropped on dummy move");

  chk_wr_from_instr: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    wr_en_reg |-> $past(ex_valid_reg) && $past(dst_defined))
    else $error("write without a defined destination");

  chk_dst_low_noext: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (if_valid_reg && !pfx_fwd) |=> dst_idx_reg[4:3] == 2'b00)
    else $error("destination above index 7 without prefix");

  chk_src_low_noext: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (if_valid_reg && !pfx_fwd) |=> src_idx_reg[4] == 1'b0)
    else $error("source above index 15 without prefix");

  chk_pfx_dst_ext: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    pfx_fwd |=> dst_idx_reg[4:3] == $past(dst_idx_reg[1:0]))
    else $error("prefix did not extend destination index");

  chk_pfx_src_ext: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    pfx_fwd |=> src_idx_reg[4] == $past(dst_idx_reg[2]))
    else $error("prefix did not extend source index");

  chk_dst_fields: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    if_valid_reg |=> dst_mod_reg == $past(instr_data[11:8]) && dst_idx_reg[2:0] == $past(instr_data[14:12]))
    else $error("destination field decoded wrong");

  chk_src_fields: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (if_valid_reg && !redirect && instr_data[15]) |=> src_rd_reg &&
      src_mod_reg == $past(instr_data[3:0]) && src_idx_reg[3:0] == $past(instr_data[7:4]))
    else $error("register source decoded wrong");

  chk_imm_no_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (if_valid_reg && !instr_data[15]) |=> !src_rd_reg)
    else $error("immediate word issued a source read");

  chk_int_dst_nowr: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ex_valid_reg && dst_int) |=> !wr_en_reg)
    else $error("internal destination reached write port");

  chk_wr_any_group: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (ex_valid_reg && !dst_int && dst_defined) |=>
      wr_en_reg && wr_mod_reg == $past(dst_mod_reg) && wr_idx_reg == $past(dst_idx_reg))
    else $error("defined destination not written");

  chk_prefix_load: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    pfx_load |=> prefix_reg == $past(cnv_val[7:0]))
    else $error("prefix data not loaded");

  chk_prefix_idle: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !pfx_load |=> prefix_reg == 8'h00)
    else $error("prefix not zero without a load");

  chk_same8_copy: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_fire && !dst_is16 && ex_regsrc_reg && !src_ip && src_defined && !src_is16) |=>
      wr_data_reg == {8'h00, $past(src_data[7:0])})
    else $error("8-bit move not copied unchanged");

  chk_narrow_hi_zero: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_fire && !dst_is16) |=> wr_data_reg[15:8] == 8'h00)
    else $error("narrow destination upper byte not zero");

  chk_widen_imm: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (wr_fire && dst_is16 && !ex_regsrc_reg) |=> wr_data_reg == {$past(prefix_reg), $past(ex_imm_reg)})
    else $error("immediate into wide register wrong");

  chk_fetch_resume: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !redirect |=> if_valid_reg && if_pc_reg == $past(ip_reg))
    else $error("sequential fetch not kept");

  chk_ipw_flush: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ipw_fire |=> !ex_valid_reg && !if_valid_reg)
    else $error("pointer write did not flush");

  chk_reset_empty: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> !if_valid_reg && !ex_valid_reg && !wr_en_reg && !src_rd_reg)
    else $error("work in flight after reset");

endmodule : rstc_core

/* sim/rstc_partner.sv */
// Purpose: Program store and register-module model facing rstc_core
// Assumes: Even modules hold 8-bit registers, odd modules 16-bit ones
// Notes:   Sub-index 7 of each group of eight is an empty location
`timescale 1ns/1ps
module rstc_partner (
  // Clock
  input  wire logic        sys_clk,
  // Program fetch
  input  wire logic [15:0] prog_addr,
  output logic      [15:0] instr_data,
  // Source query
  input  wire logic [3:0]  src_mod,
  input  wire logic [4:0]  src_idx,
  output logic      [15:0] src_data,
  output logic             src_defined,
  output logic             src_is16,
  output logic             src_mod_has8,
  // Destination query
  input  wire logic [3:0]  dst_mod,
  input  wire logic [4:0]  dst_idx,
  output logic             dst_defined,
  output logic             dst_is16
);
  // ==========================================================
  // Read-only program store, filled before the run
  logic [15:0] rom [0:255];
  always_ff @(posedge sys_clk) instr_data <= rom[prog_addr[7:0]];
  // ==========================================================
  // Register modules, 32 locations each
  assign src_defined  = src_idx[2:0] != 3'd7;
  assign src_is16     = src_mod[0];
  assign src_mod_has8 = ~src_mod[0];
  assign dst_defined  = dst_idx[2:0] != 3'd7;
  assign dst_is16     = dst_mod[0];
  // Empty locations show junk; 8-bit ones read zero above bit 7
  assign src_data = !src_defined ? ~{src_idx, src_mod, 7'h2A} :
                    src_mod[0] ? {1'b1, src_idx, 2'b01, src_mod, 4'h3} :
                    {8'h00, src_idx[3:0] ^ {src_idx[4], 3'b000}, src_mod};
endmodule : rstc_partner

/* sim/rstc_core_tb_top.sv */
// Purpose: Self-checking bench for rstc_core
// Assumes: Partner model serves program words and register answers
// Notes:   A bench model replays the program to predict every write
`timescale 1ns/1ps
module rstc_core_tb_top;
  import rstc_pkg::*;
  localparam int K = 48;
  localparam int M = 40;
  logic        sys_clk, nrst, br_load, src_rd, wr_en, pf;
  logic        src_defined, src_is16, src_mod_has8, dst_defined, dst_is16;
  rstc_addr_t  prog_addr, br_target;
  rstc_data_t  instr_data, src_data, wr_data, w;
  rstc_mod_t   src_mod, dst_mod, wr_mod;
  rstc_idx_t   src_idx, dst_idx, wr_idx;
  int          failures = 0, n_compared = 0, n_rd = 0, n_rd_exp = 0, a;
  logic [31:0] seed = 32'h0000_0003;
  logic [24:0] exp_q [$];

  rstc_core rstc_core_inst (.sys_clk, .nrst, .prog_addr, .instr_data, .br_load, .br_target,
    .src_rd, .src_mod, .src_idx, .src_data, .src_defined, .src_is16, .src_mod_has8,
    .dst_mod, .dst_idx, .dst_defined, .dst_is16, .wr_en, .wr_mod, .wr_idx, .wr_data);
  rstc_partner rstc_partner_inst (.sys_clk, .prog_addr, .instr_data, .src_mod, .src_idx,
    .src_data, .src_defined, .src_is16, .src_mod_has8, .dst_mod, .dst_idx, .dst_defined, .dst_is16);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic rstc_data_t sval(input rstc_mod_t m, input rstc_idx_t i);
    return m[0] ? {1'b1, i, 2'b01, m, 4'h3} : {8'h00, i[3:0] ^ {i[4], 3'b000}, m};
  endfunction : sval

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("failures %0d, compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Replays the program from the reset address, prefix and jumps included
  task automatic run_model();
    logic [15:0] pc, iw, v, cv;
    logic [7:0]  p;
    logic [1:0]  ed;
    logic        es, s16;
    rstc_idx_t   di, si;
    rstc_mod_t   dm, sm;
    pc = IP_RESET;
    {p, ed, es} = 11'h000;
    repeat (200) begin
      if (pc != 16'h80C0 + M) begin
        iw = rstc_partner_inst.rom[pc[7:0]];
        pc = pc + 16'h0001;
        dm = iw[11:8];
        sm = iw[3:0];
        di = {ed, iw[14:12]};
        si = {es, iw[7:4]};
        s16 = iw[15] & sm[0];
        v = iw[15] ? sval(sm, si) : {8'h00, iw[7:0]};
        if (iw[15]) n_rd_exp++;
        if (iw[15] && si[2:0] == 3'd7) begin
          v = sm[0] ? 16'h0000 : {p, 8'h00};
          s16 = 1'b1;
        end
        cv = (dm[0] || dm == IP_MOD) ? (s16 ? v : {p, v[7:0]}) : {8'h00, v[7:0]};
        {p, ed, es} = 11'h000;
        if (dm == PFX_MOD && di < 5'd8) {p, es, ed} = {cv[7:0], iw[14:12]};
        else if (dm == IP_MOD && di == IP_IDX) pc = cv;
        else if (di[2:0] != 3'd7) exp_q.push_back({dm, di, cv});
      end
    end
  endtask : run_model

  // ==========================================================
  // Clock, watchdog, write monitor
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    failures++;
    test_done();
  end

  always @(negedge sys_clk) begin
    if (src_rd === 1'b1) n_rd++;
    if (wr_en === 1'b1 && exp_q.size() == 0) check("extra write", {wr_mod, wr_idx, wr_data}, 32'hFFFF_FFFF);
    else if (wr_en === 1'b1) check("write", {wr_mod, wr_idx, wr_data}, exp_q.pop_front());
  end

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    br_load = 1'b0;
    br_target = 16'h0000;
    for (int k = 0; k < 256; k++) rstc_partner_inst.rom[k] = 16'h7000;
    // Prefixed upper destination, widening move, empty sources
    rstc_partner_inst.rom[0] = 16'h3B5A;
    rstc_partner_inst.rom[1] = 16'h9122;
    rstc_partner_inst.rom[2] = 16'h9177;
    rstc_partner_inst.rom[3] = 16'h0B33;
    rstc_partner_inst.rom[4] = 16'h9376;
    pf = 1'b0;
    for (int k = 5; k < K + M; k++) begin
      a = (k < K) ? k : k - K + 192;
      seed = xs(seed);
      w = seed[15:0];
      if (w[11:8] == IP_MOD || ((pf || k == K - 1 || k == K + M - 1) && w[11:8] == PFX_MOD)) w[11:8] = 4'h2;
      if (w[15] && (w[3:0] == PFX_MOD || w[3:0] == IP_MOD)) w[3:0] = 4'h6;
      pf = (w[11:8] == PFX_MOD);
      rstc_partner_inst.rom[a] = w;
    end
    // Jump to 80C0h through the prefix; the two words after it are dropped
    rstc_partner_inst.rom[K] = 16'h0B80;
    rstc_partner_inst.rom[K + 1] = 16'h0CC0;
    rstc_partner_inst.rom[K + 2] = 16'h0155;
    rstc_partner_inst.rom[K + 3] = 16'h0155;
    run_model();
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    check("reset address", prog_addr, IP_RESET);
    // Stop before fetch wraps past 80FFh into the start of the store
    repeat (110) @(negedge sys_clk);
    check("pending writes", exp_q.size(), 0);
    check("source reads", n_rd, n_rd_exp);
    for (int b = 0; b < 4; b++) begin
      seed = xs(seed);
      br_load = 1'b1;
      br_target = {seed[15:8], 8'hF0};
      @(negedge sys_clk);
      br_load = 1'b0;
      check("branch target", prog_addr, br_target);
      @(negedge sys_clk);
      check("next fetch", prog_addr, br_target + 16'h0001);
    end
    nrst = 1'b0;
    @(negedge sys_clk);
    check("mid-run reset", {wr_en, src_rd, prog_addr}, {2'b00, IP_RESET});
    test_done();
  end
endmodule : rstc_core_tb_top
